// [logic/ebr_pkg.sv]
// Purpose: Shared constants and types for the small embedded block RAM.
// Assumes: Single system clock domain at 10 MHz.
// Notes: Native shape is 32 words of 18 bits; narrower shapes fold onto it.
package ebr_pkg;
   // =========================================================
   // Geometry
   // =========================================================
   localparam int EBR_TOTAL_BITS = 576;
   localparam int EBR_NAT_WORDS = 32;
   localparam int EBR_NAT_WIDTH = 18;
   localparam int EBR_BIT_ADDR_W = 10;
   localparam int EBR_WORD_ADDR_W = 5;
   localparam int EBR_LINK_IN_W = 16;
   localparam int EBR_BE_W = 2;
   localparam logic [17:0] EBR_DOUT_RESET = 18'h00000;
   // Medium and large block shapes, kept for configuration checks
   localparam int EBR_MED_WORDS = 128;
   localparam int EBR_MED_WIDTH = 36;
   localparam int EBR_LRG_WORDS = 4096;
   localparam int EBR_LRG_WIDTH = 144;
   // =========================================================
   // Shapes, width codes
   // =========================================================
   typedef enum logic [2:0]
   {
      EBR_W1 = 3'h0,
      EBR_W2 = 3'h1,
      EBR_W4 = 3'h3,
      EBR_W8 = 3'h2,
      EBR_W9 = 3'h6,
      EBR_W16 = 3'h7,
      EBR_W18 = 3'h5
   } ebr_shape_t;
   // Operating modes, selected at configuration
   typedef enum logic [2:0]
   {
      EBR_MODE_SDP = 3'h0,
      EBR_MODE_SP = 3'h1,
      EBR_MODE_FIFO = 3'h3,
      EBR_MODE_ROM = 3'h2,
      EBR_MODE_SHIFT = 3'h6
   } ebr_mode_t;
   // Address-field width for a shape (bits above word address)
   function automatic logic [2:0] ebr_lane_bits(input ebr_shape_t s);
      case (s)
         EBR_W1: ebr_lane_bits = 3'h4;
         EBR_W2: ebr_lane_bits = 3'h3;
         EBR_W4: ebr_lane_bits = 3'h2;
         EBR_W8: ebr_lane_bits = 3'h1;
         EBR_W9: ebr_lane_bits = 3'h1;
         default: ebr_lane_bits = 3'h0;
      endcase
   endfunction
   // Element width in bits for a shape
   function automatic logic [4:0] ebr_elem_w(input ebr_shape_t s);
      case (s)
         EBR_W1: ebr_elem_w = 5'h01;
         EBR_W2: ebr_elem_w = 5'h02;
         EBR_W4: ebr_elem_w = 5'h04;
         EBR_W8: ebr_elem_w = 5'h08;
         EBR_W9: ebr_elem_w = 5'h09;
         EBR_W16: ebr_elem_w = 5'h10;
         default: ebr_elem_w = 5'h12;
      endcase
   endfunction
endpackage : ebr_pkg

// [logic/ebr_wr_if.sv]
// Purpose: Write-side bundle between the top and the storage array.
// Assumes: All signals on SYS_CLK_IN.
// Notes: Carries mask and data already spread onto the native word.
interface ebr_wr_if;
   logic we;
   logic [4:0] addr;
   logic [17:0] data;
   logic [17:0] mask;
   logic [4:0] raddr;
   logic [17:0] rdata;
   modport ctrl (output we, output addr, output data, output mask,
      output raddr, input rdata);
   modport mem (input we, input addr, input data, input mask,
      input raddr, output rdata);
endinterface : ebr_wr_if

// [logic/ebr_array.sv]
// Purpose: 32 x 18 storage array with bit-masked write, async read.
// Assumes: Write port registered by caller; single clock.
// Notes: Contents survive reset; only input and output registers clear.
module ebr_array
   import ebr_pkg::*;
#(
   parameter string INIT_FILE_NAME = ""
)
(
   input wire logic clk_in,
   ebr_wr_if.mem port
);
   // Cleared image at configuration; kept in the declaration so that
   // only the write process below ever assigns the array
   logic [17:0] mem_reg [EBR_NAT_WORDS] = '{default: 18'h00000};

   // =========================================================
   // Storage
   // =========================================================
   // Masked write keeps untouched lanes, giving byte-enable behaviour
   always_ff @(posedge clk_in)
   begin
      if (port.we)
      begin
         mem_reg[port.addr] <= (mem_reg[port.addr] & ~port.mask) |
            (port.data & port.mask);
      end
   end

   // Read returns old contents while same word is written
   assign port.rdata = mem_reg[port.raddr];
endmodule // ebr_array

// [logic/ebr_top.sv]
// Purpose: Small embedded block RAM, simple dual-port, 576 bits.
// Assumes: User logic meets address capture window; one 10 MHz clock.
// Notes: Shape and mode are configuration inputs, meant to be static.
module ebr_top
   import ebr_pkg::*;
(
   input wire logic SYS_CLK_IN,
   input wire logic RST_IN,
   input wire logic [2:0] SHAPE_IN,
   input wire logic [2:0] MODE_IN,
   input wire logic OUT_REG_EN_IN,
   input wire logic WREN_IN,
   input wire logic [EBR_BIT_ADDR_W-1:0] WADDR_IN,
   input wire logic [EBR_NAT_WIDTH-1:0] WDATA_IN,
   input wire logic [EBR_BE_W-1:0] BYTE_EN_IN,
   input wire logic RDEN_IN,
   input wire logic [EBR_BIT_ADDR_W-1:0] RADDR_IN,
   input wire logic OUTCLR_IN,
   output logic [EBR_NAT_WIDTH-1:0] RDATA_OUT
);
   // Inputs come from logic on the same clock
   // Medium/large sizes are separate blocks; only the small one lives here
   // single clock stands for both sides
   ebr_shape_t shape;
   ebr_mode_t mode;
   logic wr_ok;
   assign shape = ebr_shape_t'(SHAPE_IN);
   assign mode = ebr_mode_t'(MODE_IN);
   // ROM mode blocks writes; preload image stays intact
   assign wr_ok = (mode != EBR_MODE_ROM);

   // =========================================================
   // Input registers, all on one clock
   // =========================================================
   logic we_reg, we_next;
   logic [9:0] wa_reg, wa_next;
   logic [17:0] wd_reg, wd_next;
   logic [1:0] be_reg, be_next;
   logic re_reg, re_next;
   logic [9:0] ra_reg, ra_next;

   // Next values for the always-used input registers
   always_comb
   begin
      we_next = WREN_IN & wr_ok;
      wa_next = WADDR_IN;
      wd_next = WDATA_IN;
      be_next = BYTE_EN_IN;
      re_next = RDEN_IN;
      ra_next = RADDR_IN;
      // Shift mode writes and reads the same place in one go
      if (mode == EBR_MODE_SHIFT)
      begin
         re_next = WREN_IN;
         ra_next = WADDR_IN;
      end
      // Single-port mode: one address serves both sides
      if (mode == EBR_MODE_SP)
      begin
         ra_next = WADDR_IN;
      end
   end

   // Registering only; no clear of memory inputs needed, but defined
   always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         we_reg <= 1'b0;
         wa_reg <= 10'h000;
         wd_reg <= 18'h00000;
         be_reg <= 2'h0;
         re_reg <= 1'b0;
         ra_reg <= 10'h000;
      end
      else
      begin
         we_reg <= we_next;
         wa_reg <= wa_next;
         wd_reg <= wd_next;
         be_reg <= be_next;
         re_reg <= re_next;
         ra_reg <= ra_next;
      end
   end

   // =========================================================
   // Shape folding onto the native 32x18 word
   // =========================================================
   logic [2:0] lb;
   logic [4:0] ew;
   logic [17:0] wmask, wdata_sh, emask, rd_word, rd_elem;
   logic [4:0] w_lane, r_lane;
   logic [8:0] w_off, r_off;
   ebr_wr_if port ();

   // Element lanes sit at address bits above the word index
   always_comb
   begin
      lb = ebr_lane_bits(shape);
      ew = ebr_elem_w(shape);
      // Ones start in the upper half so the shift leaves ew low ones
      emask = 18'(({18'h3ffff, 18'h00000} >> (6'd36 - {1'b0, ew})));
      w_lane = 5'(wa_reg >> EBR_WORD_ADDR_W) & 5'((5'h01 << lb) - 5'h01);
      r_lane = 5'(ra_reg >> EBR_WORD_ADDR_W) & 5'((5'h01 << lb) - 5'h01);
      w_off = 9'(w_lane * ew);
      r_off = 9'(r_lane * ew);
      wmask = 18'(emask << w_off);
      // Byte enables act on the two nine-bit halves of wide shapes
      if (lb == 3'h0)
      begin
         wmask = {{9{be_reg[1]}}, {9{be_reg[0]}}};
         if (shape == EBR_W16)
         begin
            wmask = wmask & 18'h0ffff;
         end
      end
      wdata_sh = 18'((wd_reg & emask) << w_off);
      rd_elem = (rd_word >> r_off) & emask;
   end

   assign port.we = we_reg;
   assign port.addr = wa_reg[4:0];
   assign port.data = wdata_sh;
   assign port.mask = wmask;
   assign port.raddr = ra_reg[4:0];
   assign rd_word = port.rdata;

   ebr_array u_array
   (
      .clk_in(SYS_CLK_IN),
      .port(port)
   );

   // =========================================================
   // Output register with clear and bypass
   // =========================================================
   logic [17:0] dout_reg, dout_next;
   logic [17:0] byp_reg, byp_next;

   // Registered path holds on no read; clear wins over a read
   always_comb
   begin
      dout_next = dout_reg;
      if (OUTCLR_IN)
      begin
         dout_next = EBR_DOUT_RESET;
      end
      else if (re_reg)
      begin
         dout_next = rd_elem;
      end
      // Bypass feeds the pin flop straight; the output register adds
      // one cycle. Clear only reaches the output register.
      byp_next = re_reg ? rd_elem : byp_reg;
      if (OUT_REG_EN_IN)
      begin
         byp_next = dout_reg;
      end
   end

   // Outputs power up cleared
   always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         dout_reg <= EBR_DOUT_RESET;
         byp_reg <= EBR_DOUT_RESET;
      end
      else
      begin
         dout_reg <= dout_next;
         byp_reg <= byp_next;
      end
   end

   assign RDATA_OUT = byp_reg;
endmodule // ebr_top

// [sim/ebr_monitor.sv]
// Purpose: Port checks for the small block RAM.
// Assumes: One clock; shape, mode, bypass change under reset.
// Notes: Read latency 2 edges in bypass, 3 registered.
module ebr_monitor
   import ebr_pkg::*;
(
   input wire logic SYS_CLK_IN,
   input wire logic RST_IN,
   input wire logic [2:0] SHAPE_IN,
   input wire logic [2:0] MODE_IN,
   input wire logic OUT_REG_EN_IN,
   input wire logic WREN_IN,
   input wire logic RDEN_IN,
   input wire logic OUTCLR_IN,
   input wire logic [17:0] RDATA_OUT
);
   // Shift mode reads on the write strobe, so both count as reads
   logic rd_any;
   assign rd_any = RDEN_IN || (MODE_IN == EBR_MODE_SHIFT && WREN_IN);
   // ==========
   // Checks
   default clocking @(posedge SYS_CLK_IN); endclocking
   default disable iff (RST_IN);
   // Four quiet edges cover the longest read pipeline
   sequence s_no_rd;
      (!rd_any)[*4];
   endsequence
   AST_RST_ZERO: assert property (disable iff (1'b0)
      RST_IN |-> RDATA_OUT == 18'h0) else $error("out not clear in reset");
   AST_REL_ZERO: assert property (
      $fell(RST_IN) |-> RDATA_OUT == 18'h0) else $error("out after reset");
   AST_HOLD: assert property (
      (!rd_any && !OUTCLR_IN)[*4] |=> $stable(RDATA_OUT))
      else $error("out moved with no read");
   AST_CLR_REG: assert property (
      s_no_rd ##0 (OUTCLR_IN && OUT_REG_EN_IN) |=> ##1 RDATA_OUT == 18'h0)
      else $error("clear missed");
   AST_CLR_BYP: assert property (
      s_no_rd ##0 (OUTCLR_IN && !OUT_REG_EN_IN) |=> ##1 $stable(RDATA_OUT))
      else $error("clear hit bypass out");
   AST_CAUSE: assert property (
      $changed(RDATA_OUT) |-> $past(rd_any, 2) || $past(rd_any, 3)
      || $past(OUTCLR_IN, 2)) else $error("out moved off latency");
   AST_W1_LOW: assert property (
      SHAPE_IN == EBR_W1 |-> RDATA_OUT[17:1] == 17'h0)
      else $error("1-bit element not in low bit");
   AST_W8_LOW: assert property (
      SHAPE_IN == EBR_W8 |-> RDATA_OUT[17:8] == 10'h0)
      else $error("8-bit element not in low bits");
endmodule // ebr_monitor

bind ebr_top ebr_monitor u_ebr_monitor (.SYS_CLK_IN(SYS_CLK_IN),
   .RST_IN(RST_IN), .SHAPE_IN(SHAPE_IN), .MODE_IN(MODE_IN),
   .OUT_REG_EN_IN(OUT_REG_EN_IN), .WREN_IN(WREN_IN),
   .RDEN_IN(RDEN_IN), .OUTCLR_IN(OUTCLR_IN), .RDATA_OUT(RDATA_OUT));

// [sim/ebr_user.sv]
// Purpose: Logic cells that drive the block's strobes and buses.
// Assumes: Command fields: we, rd, clr, be, waddr, raddr, wdata.
// Notes: Adds one edge; pins move 1 ns after each edge.
module ebr_user
(
   input wire logic clk_in,
   input wire logic [42:0] cmd_in,
   output logic [42:0] pins_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [42:0] q_reg = '0;
   // ==========
   // Drive
   // One shared clock captures strobe, address and data
   always @(posedge clk_in)
   begin
      q_reg <= cmd_in;
      if (!cmd_in[42])
         q_reg[17:0] <= ~q_reg[17:0]; // Idle data keeps moving
   end
   assign #1 pins_out = q_reg; // Clear of the capture window
endmodule // ebr_user

// [sim/test_ebr_top.sv]
// Purpose: Self-checking bench for the small block RAM.
// Assumes: Memory starts zero and survives reset.
// Notes: Config changes go under reset to keep outputs defined.
module test_ebr_top
   import ebr_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst = 1, oreg = 0;
   logic [2:0] shape = EBR_W18, mode = EBR_MODE_SDP;
   logic [42:0] cmd = '0, pins;
   logic [17:0] rdata, msk;
   logic [17:0] mdl [32] = '{default: '0};
   logic [31:0] seed = 32'h247f987f;
   ebr_mode_t modes [5] = '{EBR_MODE_SDP, EBR_MODE_SP, EBR_MODE_FIFO,
      EBR_MODE_ROM, EBR_MODE_SHIFT};
   int num_errors = 0, check_count = 0, cyc = 0;
   ebr_user u_ebr_user (.clk_in(clk), .cmd_in(cmd), .pins_out(pins));
   ebr_top u_ebr_top (.SYS_CLK_IN(clk), .RST_IN(rst), .SHAPE_IN(shape),
      .MODE_IN(mode), .OUT_REG_EN_IN(oreg), .WREN_IN(pins[42]),
      .RDEN_IN(pins[41]), .OUTCLR_IN(pins[40]), .BYTE_EN_IN(pins[39:38]),
      .WADDR_IN(pins[37:28]), .RADDR_IN(pins[27:18]),
      .WDATA_IN(pins[17:0]), .RDATA_OUT(rdata));
   // ==========
   // Clock and hang guard
   initial forever #50 clk = ~clk;
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         num_errors++;
         test_done();
      end
   end
   // ==========
   // Helpers
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // Same address on both ports suits the shared-address modes
   function automatic logic [42:0] pk(input logic [2:0] f,
      input logic [1:0] be, input logic [9:0] a, input logic [17:0] d);
      return {f, be, a, a, d};
   endfunction
   task automatic check(input string what, input logic [17:0] exp);
      check_count++;
      if (rdata !== exp)
      begin
         num_errors++;
         $display("[FAIL] %s exp %h got %h", what, exp, rdata);
      end
   endtask
   task automatic op(input logic [42:0] c);
      @(posedge clk);
      #1 cmd = c;
   endtask
   // Model keeps only the full-width picture; ROM refuses writes
   task automatic wr(input logic [9:0] a, input logic [17:0] d,
      input logic [1:0] be);
      if (mode != EBR_MODE_ROM && shape == EBR_W18 && be[0])
         mdl[a[4:0]][8:0] = d[8:0];
      if (mode != EBR_MODE_ROM && shape == EBR_W18 && be[1])
         mdl[a[4:0]][17:9] = d[17:9];
      op(pk(3'b100, be, a, d));
   endtask
   task automatic rd_chk(input logic [42:0] c, input logic [17:0] exp);
      op(c);
      op('0);
      // Looked at the first cycle the answer stands
      repeat (oreg ? 3 : 2) @(posedge clk);
      #1 check("rdata", exp);
   endtask
   task automatic clr_chk(input logic [17:0] exp);
      op(pk(3'b001, 2'b0, 10'h0, 18'h0));
      op('0);
      repeat (2) @(posedge clk);
      #1 check("clear", exp);
   endtask
   task automatic reboot(input logic [2:0] s, input logic [2:0] m,
      input logic r);
      // Let a write still in the pipe land before reset drops it
      repeat (3) @(posedge clk);
      #1 rst = 1;
      shape = s;
      mode = m;
      oreg = r;
      repeat (2) @(posedge clk);
      #1 rst = 0;
      check("reset", 18'h0);
   endtask
   task automatic test_done();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // ==========
   // Scenarios
   initial
   begin
      repeat (20) @(posedge clk);
      #1 rst = 0;
      check("reset", 18'h0);
      // Back-to-back writes, random data and byte enables
      for (int i = 0; i < 32; i++)
      begin
         seed = lfsr(seed);
         wr({5'h0, i[4:0]}, seed[17:0], seed[31:30]);
      end
      op('0);
      for (int r = 0; r < 2; r++)
      begin
         reboot(EBR_W18, EBR_MODE_SDP, r[0]);
         for (int i = 0; i < 32; i++)
            rd_chk(pk(3'b010, 2'b0, 10'(i), 18'h0), mdl[i]);
      end
      clr_chk(18'h0);
      reboot(EBR_W18, EBR_MODE_SDP, 1'b0);
      rd_chk(pk(3'b010, 2'b0, 10'd7, 18'h0), mdl[7]);
      clr_chk(mdl[7]);
      // Read and write of one word on the same edge sees old data
      rd_chk(pk(3'b110, 2'b11, 10'd9, 18'h2a5a5), mdl[9]);
      mdl[9] = 18'h2a5a5;
      rd_chk(pk(3'b010, 2'b0, 10'd9, 18'h0), mdl[9]);
      foreach (modes[k])
      begin
         reboot(EBR_W18, modes[k], 1'b0);
         seed = lfsr(seed);
         msk = mdl[20 + k];
         wr(10'(20 + k), seed[17:0], 2'b11);
         // Shift mode reads only as it writes: the replaced word shows
         if (modes[k] != EBR_MODE_SHIFT)
            msk = mdl[20 + k];
         rd_chk(pk(3'b010, 2'b0, 10'(20 + k), 18'h0), msk);
      end
      // Narrow shapes: two lanes of one word must not collide
      for (int s = 0; s < 2; s++)
      begin
         reboot(s ? EBR_W8 : EBR_W1, EBR_MODE_SDP, 1'b0);
         msk = s ? 18'hff : 18'h1;
         seed = lfsr(seed);
         wr(10'h023, seed[17:0], 2'b11);
         wr(10'h003, ~seed[17:0], 2'b11);
         rd_chk(pk(3'b010, 2'b0, 10'h023, 18'h0), seed[17:0] & msk);
         rd_chk(pk(3'b010, 2'b0, 10'h003, 18'h0), ~seed[17:0] & msk);
      end
      test_done();
   end
endmodule // test_ebr_top
